// ### prog_addr_pkg.sv
// Constants and types shared by the program-memory addressing logic
// Behaviour
// - Separate program and data buses, concurrent access
// - Thirteen-bit counter addresses 8K words of fourteen bits
// - Only lower 4K fourteen-bit words are implemented
// - Fetches above implemented range wrap around
// - Reset starts fetching at address zero
// - Taken interrupt fetches next from address four
package prog_addr_pkg;
    localparam int PC_W = 13;
    localparam int WORD_W = 14;
    localparam int IMPL_AW = 12;
    localparam int DATA_AW = 9;
    localparam int DATA_W = 8;
    localparam logic [12:0] RESET_VEC = 13'h0000;
    localparam logic [12:0] INT_VEC = 13'h0004;
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [13:0] WORD_RST = 14'h0000;
    localparam logic [7:0] DATA_RST = 8'h00;

    typedef enum logic [1:0] {
        PC_STEP = 2'b00,
        PC_JUMP = 2'b01,
        PC_HOLD = 2'b10
    } pc_op_t;
endpackage

// ### prog_fetch_if.sv
// Carrier between the addressing logic and its program store
`timescale 1ns/1ps
interface prog_fetch_if #(
    parameter int AW = 12,
    parameter int DW = 14
);
    logic [AW-1:0] addr;
    logic [DW-1:0] word;
    modport core (output addr, input word);
    modport store (input addr, output word);
endinterface

// ### prog_store.sv
// Program store of implemented words, addressed on its own bus
`timescale 1ns/1ps
module prog_store
    import prog_addr_pkg::*;
#(
    parameter int AW = IMPL_AW,
    parameter int DW = WORD_W
) (
    // Clock
    input wire logic core_clk,
    // Fetch side
    prog_fetch_if.store fetch,
    // Load side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_word
);
    // Only the implemented words exist
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_word;
        end
    end

    assign fetch.word = mem[fetch.addr];
endmodule

// ### prog_addr.sv
// Program counter, vectors, wrap and the separate program and data buses
`timescale 1ns/1ps
module prog_addr
    import prog_addr_pkg::*;
#(
    parameter int PW = PC_W,
    parameter int AW = IMPL_AW,
    parameter int DW = WORD_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Sequencing requests
    input wire logic step,
    input wire logic jump,
    input wire logic [12:0] jump_addr,
    input wire logic irq_take,
    // Program load port
    input wire logic load_en,
    input wire logic [11:0] load_addr,
    input wire logic [13:0] load_word,
    // Data-side request, independent of fetches
    input wire logic data_req,
    input wire logic data_we,
    input wire logic [8:0] data_addr,
    input wire logic [7:0] data_wdata,
    // Fetch results
    output logic [12:0] pc,
    output logic [13:0] instr,
    output logic instr_valid,
    // Data-side outputs
    output logic data_strobe,
    output logic data_write,
    output logic [8:0] data_addr_out,
    output logic [7:0] data_wdata_out
);
    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks: the datapath below is sized for these values

    if (PW != PC_W) begin : g_bad_pw
        $error("prog_addr: counter width must be %0d", PC_W);
    end
    if (AW != IMPL_AW) begin : g_bad_aw
        $error("prog_addr: store address width must be %0d", IMPL_AW);
    end
    if (DW != WORD_W) begin : g_bad_dw
        $error("prog_addr: word width must be %0d", WORD_W);
    end
    if (AW >= PW) begin : g_bad_wrap
        $error("prog_addr: store must be smaller than the counter space");
    end
    if (int'(RESET_VEC) >= (1 << IMPL_AW)) begin : g_bad_rvec
        $error("prog_addr: reset vector lies outside the store");
    end
    if (int'(INT_VEC) >= (1 << IMPL_AW)) begin : g_bad_ivec
        $error("prog_addr: interrupt vector lies outside the store");
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter

    logic [12:0] pc_r, pc_nxt;
    pc_op_t op;
    logic [12:0] target;
    logic fetch_now;

    // Interrupt outranks jump, jump outranks step
    always_comb begin
        op = PC_HOLD;
        target = pc_r;
        if (irq_take) begin
            op = PC_JUMP;
            target = INT_VEC;
        end else if (jump) begin
            op = PC_JUMP;
            target = jump_addr;
        end else if (step) begin
            op = PC_STEP;
        end
    end

    // Every accepted request retires the word at the current counter
    assign fetch_now = step | jump | irq_take;

    always_comb begin
        case (op)
            PC_STEP: begin
                pc_nxt = 13'(pc_r + 13'h0001);
            end
            PC_JUMP: begin
                pc_nxt = target;
            end
            PC_HOLD: begin
                pc_nxt = pc_r;
            end
            default: begin
                pc_nxt = pc_r;
            end
        endcase
        if (rst) begin
            pc_nxt = RESET_VEC;
        end
    end

    always_ff @(posedge core_clk) begin
        pc_r <= pc_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Fetch over the program bus

    logic [13:0] instr_r, instr_nxt;
    logic valid_r, valid_nxt;
    prog_fetch_if #(.AW(IMPL_AW), .DW(WORD_W)) fbus ();

    // Top counter bit is ignored, so addresses wrap modulo the store size
    assign fbus.addr = pc_r[IMPL_AW-1:0];

    prog_store #(.AW(IMPL_AW), .DW(WORD_W)) u_store (
        .core_clk(core_clk),
        .fetch(fbus),
        .wr_en(load_en),
        .wr_addr(load_addr),
        .wr_word(load_word)
    );

    // The word at the counter before it moves is the one retired
    always_comb begin
        instr_nxt = instr_r;
        if (fetch_now) begin
            instr_nxt = fbus.word;
        end
        if (rst) begin
            instr_nxt = WORD_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        instr_r <= instr_nxt;
    end

    // Valid marks the single cycle after each fetch
    always_comb begin
        valid_nxt = fetch_now;
        if (rst) begin
            valid_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        valid_r <= valid_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Data bus, its own registers so it runs alongside every fetch

    logic ds_r, ds_nxt;
    logic dw_r, dw_nxt;
    logic [DATA_AW-1:0] da_r, da_nxt;
    logic [DATA_W-1:0] dd_r, dd_nxt;

    // Strobe lasts one cycle per request
    always_comb begin
        ds_nxt = data_req;
        if (rst) begin
            ds_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        ds_r <= ds_nxt;
    end

    // Write flag follows the strobe for write requests only
    always_comb begin
        dw_nxt = data_req & data_we;
        if (rst) begin
            dw_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        dw_r <= dw_nxt;
    end

    // Address holds until the next request
    always_comb begin
        da_nxt = da_r;
        if (data_req) begin
            da_nxt = data_addr;
        end
        if (rst) begin
            da_nxt = 9'h000;
        end
    end

    always_ff @(posedge core_clk) begin
        da_r <= da_nxt;
    end

    // Write data holds until the next write request
    always_comb begin
        dd_nxt = dd_r;
        if (data_req && data_we) begin
            dd_nxt = data_wdata;
        end
        if (rst) begin
            dd_nxt = DATA_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        dd_r <= dd_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from its flip-flop

    assign pc = pc_r;
    assign instr = instr_r;
    assign instr_valid = valid_r;
    assign data_strobe = ds_r;
    assign data_write = dw_r;
    assign data_addr_out = da_r;
    assign data_wdata_out = dd_r;
endmodule

// ### prog_addr_props.sv
// Checker for pc sequencing and the data side
`timescale 1ns/1ps
module prog_addr_props (
    // Clock, reset and requests
    input wire logic core_clk,
    input wire logic rst,
    input wire logic step,
    input wire logic jump,
    input wire logic [12:0] jump_addr,
    input wire logic irq_take,
    input wire logic data_req,
    input wire logic data_we,
    // Results
    input wire logic [12:0] pc,
    input wire logic instr_valid,
    input wire logic data_strobe,
    input wire logic data_write
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    start_vec_a: assert property ($fell(rst) |-> pc == 13'h0000) else $error("pc");
    int_vec_a: assert property (irq_take |=> pc == 13'h0004) else $error("irq");
    jump_pc_a: assert property (jump && !irq_take |=> pc == $past(jump_addr))
        else $error("jump");
    step_pc_a: assert property (step && !jump && !irq_take |=> pc == $past(pc) + 13'h1)
        else $error("step");
    idle_pc_a: assert property (!(step | jump | irq_take) |=> $stable(pc) && !instr_valid)
        else $error("idle");
    data_strobe_a: assert property (data_req |=> data_strobe) else $error("data");
    fetch_valid_a: assert property ((step | jump | irq_take) |=> instr_valid)
        else $error("fetch");
    data_write_a: assert property (data_req && data_we |=> data_write)
        else $error("write");
    data_idle_a: assert property (!data_req |=> !data_strobe && !data_write)
        else $error("data idle");
endmodule
bind prog_addr prog_addr_props props (
    .core_clk(core_clk),
    .rst(rst),
    .step(step),
    .jump(jump),
    .jump_addr(jump_addr),
    .irq_take(irq_take),
    .data_req(data_req),
    .data_we(data_we),
    .pc(pc),
    .instr_valid(instr_valid),
    .data_strobe(data_strobe),
    .data_write(data_write)
);

// ### prog_image.sv
// Loader that fills the program array with a known image
`timescale 1ns/1ps
module prog_image (
    // Clock and load port
    input wire logic core_clk,
    output logic load_en = 0,
    output logic [11:0] load_addr = 0,
    output logic [13:0] load_word = 0,
    output logic done = 0
);
    initial begin
        repeat (8) @(posedge core_clk);
        for (int a = 0; a < 4096; a++) begin
            load_en <= 1;
            {load_addr, load_word} <= {a[11:0], a[11:0], 2'b10} ^ 26'h1555;
            @(posedge core_clk);
        end
        {load_en, done} <= 2'b01;
    end
endmodule

// ### prog_addr_tb.sv
// Random and corner bench for program addressing
`timescale 1ns/1ps
module prog_addr_tb;
    import prog_addr_pkg::*;
    logic core_clk = 0, rst = 1, step = 0, jump = 0, irq_take = 0, data_req = 0;
    logic data_we = 0, load_en, instr_valid, data_strobe, data_write, done, f, pr, pw;
    logic [12:0] jump_addr = 0, pc, ep, op;
    logic [11:0] load_addr;
    logic [13:0] load_word, instr, ei;
    logic [8:0] data_addr = 0, data_addr_out, pa;
    logic [7:0] data_wdata = 0, data_wdata_out, pd;
    int n_mismatch = 0, comparisons = 0, seed = 51362;
    prog_addr dut (
        .core_clk(core_clk),
        .rst(rst),
        .step(step),
        .jump(jump),
        .jump_addr(jump_addr),
        .irq_take(irq_take),
        .load_en(load_en),
        .load_addr(load_addr),
        .load_word(load_word),
        .data_req(data_req),
        .data_we(data_we),
        .data_addr(data_addr),
        .data_wdata(data_wdata),
        .pc(pc),
        .instr(instr),
        .instr_valid(instr_valid),
        .data_strobe(data_strobe),
        .data_write(data_write),
        .data_addr_out(data_addr_out),
        .data_wdata_out(data_wdata_out)
    );
    prog_image img (
        .core_clk(core_clk),
        .load_en(load_en),
        .load_addr(load_addr),
        .load_word(load_word),
        .done(done)
    );
    initial forever #5 core_clk = ~core_clk;
    function automatic logic [13:0] word_at(logic [12:0] a);
        return {a[11:0], 2'b10} ^ 14'h1555;
    endfunction
    task automatic chk(logic [13:0] seen, logic [13:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(logic s, logic j, logic [12:0] a, logic i);
        @(posedge core_clk);
        {step, jump, jump_addr, irq_take} <= {s, j, a, i};
        data_req <= 1'($random(seed));
        data_we <= 1'($random(seed));
        data_addr <= 9'($random(seed));
        data_wdata <= 8'($random(seed));
        @(negedge core_clk);
        chk(pc, ep);
        chk(instr_valid, f);
        if (f) ei = word_at(op);
        chk(instr, ei);
        chk(data_strobe, pr);
        chk(data_write, pw);
        chk(data_addr_out, pa);
        chk(data_wdata_out, pd);
        {op, f, pr, pw} = {ep, s | j | i, data_req, data_req & data_we};
        if (data_req) pa = data_addr;
        if (data_req && data_we) pd = data_wdata;
        ep = i ? INT_VEC : j ? a : ep + 13'(s);
    endtask
    task automatic rs();
        @(posedge core_clk);
        {rst, step, jump, irq_take, data_req} <= 5'h10;
        repeat (3) @(posedge core_clk);
        rst <= 0;
        {ep, f, pr, pw, ei, pa, pd} = '0;
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        rs();
        wait (done);
        cyc(1, 0, 0, 0);
        cyc(0, 1, 13'h1FFF, 0);
        cyc(1, 0, 0, 0);
        cyc(0, 1, 13'h1005, 0);
        cyc(1, 0, 0, 1);
        cyc(1, 1, 13'h0777, 0);
        $display("corner test done");
        repeat (400) cyc(1'($random(seed)), 1'($random(seed)), 13'($random(seed)),
            ($random(seed) & 7) == 0);
        $display("random test done");
        rs();
        cyc(0, 0, 0, 0);
        cyc(0, 0, 0, 0);
        $display("reset test done");
        end_sim();
    end
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end
endmodule
